// ==== hdl/ef_sector_pkg.sv ====
// Constants for the earth-fault sector configuration decoder.
// Assumes a single 20 MHz clock domain; no bus, switches arrive on plain ports.
package ef_sector_pkg;
    localparam int SW_WIDTH = 8;
    localparam int ANGLE_WIDTH = 8;
    // Switch positions within the option switchgroup
    localparam int POS_PRINCIPLE = 0;
    localparam int POS_STORAGE = 1;
    localparam int POS_NEG_A = 2;
    localparam int POS_NEG_B = 3;
    localparam int POS_POS_A = 4;
    localparam int POS_POS_B = 5;
    localparam logic [7:0] SW_RESET = 8'h00;
    // Sector limits as magnitudes in degrees
    localparam logic [7:0] NEG_NARROW = 8'h50;
    localparam logic [7:0] NEG_WIDE = 8'h58;
    localparam logic [7:0] NEG_120 = 8'h78;
    localparam logic [7:0] NEG_170 = 8'hAA;
    localparam logic [7:0] POS_80 = 8'h50;
    localparam logic [7:0] POS_70 = 8'h46;
    localparam logic [7:0] POS_60 = 8'h3C;
    localparam logic [7:0] WIDE_SHIFT = 8'h08;
    typedef enum logic [1:0] {
        PRINC_ANGLE = 2'h1,
        PRINC_ACTIVE = 2'h2
    } principle_t;
endpackage : ef_sector_pkg

// ==== hdl/earth_fault_sector_config.sv ====
// Decoder of the earth-fault option switchgroup into sector limits and principles.
// Assumes front panel and serial host present single-cycle write strobes.
//
// Contract
// R1 - Principle switch 0 selects phase angle, 1 selects active current.
// R2 - Negative 120 or 170 forces angle negative side, active-current positive side.
// R3 - Storage switch 0 means volatile records, 1 means non-volatile.
// R4 - Negative patterns 00:-80/-88, 10:-120, 01:-170, 11:-120.
// R5 - Positive patterns 00:+80, 10:+70, 01 and 11:+60.
// R6 - Wide bit adds 8 degrees to positive limits, both stages.
// R7 - Panel write or serial parameter write update the same switchgroup.
// R8 - Non-volatile records survive supply loss only if a trip occurred.
// R9 - Decoded settings update only at a measurement evaluation strobe; keepOnSupplyLoss updates on every mclk edge.
`timescale 1ns/1ps
module earth_fault_sector_config
    import ef_sector_pkg::*;
(
    input wire logic mclk,
    input wire logic arst_n,
    input wire logic panelWrite,
    input wire logic [SW_WIDTH-1:0] panelData,
    input wire logic remoteWrite,
    input wire logic [SW_WIDTH-1:0] remoteData,
    input wire logic wide_sector_bit,
    input wire logic evalStrobe,
    input wire logic recordHasTrip,
    output logic [SW_WIDTH-1:0] earth_fault_option_switches,
    output principle_t negPrinciple,
    output principle_t posPrinciple,
    output logic [ANGLE_WIDTH-1:0] negLimit,
    output logic [ANGLE_WIDTH-1:0] posLimit,
    output logic keepOnSupplyLoss
);
    logic [SW_WIDTH-1:0] sw_reg;
    logic [SW_WIDTH-1:0] sw_next;
    logic [ANGLE_WIDTH-1:0] negLimit_reg;
    logic [ANGLE_WIDTH-1:0] posLimit_reg;
    principle_t negPrinc_reg;
    principle_t posPrinc_reg;
    logic keep_reg;

    // Fixed switch positions and 8-bit sector constants bound the widths
    if (SW_WIDTH <= POS_POS_B) begin : g_sw_width_check
        $error("switchgroup narrower than its switch positions");
    end
    if (ANGLE_WIDTH != $bits(NEG_170)) begin : g_angle_width_check
        $error("angle width differs from the sector constants");
    end

    wire logic principle_select = sw_reg[POS_PRINCIPLE];
    wire logic record_storage_select = sw_reg[POS_STORAGE];
    wire logic [1:0] negSel = {sw_reg[POS_NEG_B], sw_reg[POS_NEG_A]};
    wire logic [1:0] posSel = {sw_reg[POS_POS_B], sw_reg[POS_POS_A]};

    // R7 shared switchgroup; serial wins a same-cycle clash as the later command
    assign sw_next = remoteWrite ? remoteData : (panelWrite ? panelData : sw_reg);

    // R4 negative decode
    wire logic [ANGLE_WIDTH-1:0] negDecoded =
        (negSel == 2'h0) ? (wide_sector_bit ? NEG_WIDE : NEG_NARROW) :
        (negSel == 2'h2) ? NEG_170 : NEG_120;
    // R5 positive decode
    wire logic [ANGLE_WIDTH-1:0] posBase =
        (posSel == 2'h0) ? POS_80 : (posSel == 2'h1) ? POS_70 : POS_60;
    // R6 wide sector shift
    wire logic [ANGLE_WIDTH-1:0] posDecoded = wide_sector_bit ? posBase + WIDE_SHIFT : posBase;
    // R2 extended negative sector forces mixed principle
    wire logic extendedNeg = negSel != 2'h0;
    // R1 principle select
    wire principle_t basePrinc = principle_select ? PRINC_ACTIVE : PRINC_ANGLE;
    wire principle_t negDecPrinc = extendedNeg ? PRINC_ANGLE : basePrinc;
    wire principle_t posDecPrinc = extendedNeg ? PRINC_ACTIVE : basePrinc;
    // R3 R8 retain only non-volatile records holding a trip
    wire logic keepDecoded = record_storage_select & recordHasTrip;

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            sw_reg <= SW_RESET;
        end else begin
            sw_reg <= sw_next;
        end
    end

    // R9 settings latched at evaluation boundary only
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            negLimit_reg <= NEG_NARROW;
            posLimit_reg <= POS_80;
            negPrinc_reg <= PRINC_ANGLE;
            posPrinc_reg <= PRINC_ANGLE;
        end else if (evalStrobe) begin
            negLimit_reg <= negDecoded;
            posLimit_reg <= posDecoded;
            negPrinc_reg <= negDecPrinc;
            posPrinc_reg <= posDecPrinc;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            keep_reg <= 1'b0;
        end else begin
            keep_reg <= keepDecoded;
        end
    end

    assign earth_fault_option_switches = sw_reg;
    assign negLimit = negLimit_reg;
    assign posLimit = posLimit_reg;
    assign negPrinciple = negPrinc_reg;
    assign posPrinciple = posPrinc_reg;
    assign keepOnSupplyLoss = keep_reg;

    // R7 remote write lands
    remote_write_a: assert property (@(posedge mclk) disable iff (!arst_n) // R7
        remoteWrite |=> earth_fault_option_switches == $past(remoteData))
        else $error("remote write not stored");
    // R7 panel write lands
    panel_write_a: assert property (@(posedge mclk) disable iff (!arst_n) // R7
        panelWrite && !remoteWrite |=> earth_fault_option_switches == $past(panelData))
        else $error("panel write not stored");
    // R7 serial wins clash
    remote_wins_a: assert property (@(posedge mclk) disable iff (!arst_n) // R7
        remoteWrite && panelWrite |=> earth_fault_option_switches == $past(remoteData))
        else $error("panel write beat a same-cycle serial write");
    // R7 switches hold idle
    switches_hold_a: assert property (@(posedge mclk) disable iff (!arst_n) // R7
        !remoteWrite && !panelWrite |=> $stable(earth_fault_option_switches))
        else $error("switchgroup moved without a write");

    // R9 hold between strobes
    limits_hold_a: assert property (@(posedge mclk) disable iff (!arst_n) // R9
        !evalStrobe |=> $stable(negLimit) && $stable(posLimit)
        && $stable(negPrinciple) && $stable(posPrinciple))
        else $error("settings moved without evaluation strobe");

    // Switch values come from the strobe cycle, since a write may land at that edge
    // R1 principle follows switch
    principle_sel_a: assert property (@(posedge mclk) disable iff (!arst_n) // R1
        evalStrobe && !extendedNeg |=>
        posPrinciple == ($past(principle_select) ? PRINC_ACTIVE : PRINC_ANGLE))
        else $error("principle does not follow switch");
    // R1 negative principle follows
    neg_principle_a: assert property (@(posedge mclk) disable iff (!arst_n) // R1
        evalStrobe && !extendedNeg |=>
        negPrinciple == ($past(principle_select) ? PRINC_ACTIVE : PRINC_ANGLE))
        else $error("negative principle does not follow switch");
    // R1 principle codes one-hot
    principle_onehot_a: assert property (@(posedge mclk) disable iff (!arst_n) // R1
        $onehot(negPrinciple) && $onehot(posPrinciple))
        else $error("principle code not one-hot");
    // R2 mixed principle forced
    mixed_force_a: assert property (@(posedge mclk) disable iff (!arst_n) // R2
        evalStrobe && extendedNeg |=>
        negPrinciple == PRINC_ANGLE && posPrinciple == PRINC_ACTIVE)
        else $error("extended sector did not force mixed principle");

    // R4 negative limits
    neg_limit_a: assert property (@(posedge mclk) disable iff (!arst_n) // R4
        evalStrobe && negSel == 2'h1 |=> negLimit == NEG_120)
        else $error("pattern 10 not -120");
    // R4 far negative sector
    neg_170_a: assert property (@(posedge mclk) disable iff (!arst_n) // R4
        evalStrobe && negSel == 2'h2 |=> negLimit == NEG_170)
        else $error("pattern 01 not -170");
    // R4 both negative switches
    neg_both_a: assert property (@(posedge mclk) disable iff (!arst_n) // R4
        evalStrobe && negSel == 2'h3 |=> negLimit == NEG_120)
        else $error("pattern 11 not -120");
    // R4 narrow negative
    neg_narrow_a: assert property (@(posedge mclk) disable iff (!arst_n) // R4
        evalStrobe && negSel == 2'h0 && !wide_sector_bit |=> negLimit == NEG_NARROW)
        else $error("narrow sector not -80");
    // R4 wide negative
    neg_wide_a: assert property (@(posedge mclk) disable iff (!arst_n) // R4
        evalStrobe && negSel == 2'h0 && wide_sector_bit |=> negLimit == NEG_WIDE)
        else $error("wide narrow sector not -88");

    // R5 positive limit
    pos_limit_a: assert property (@(posedge mclk) disable iff (!arst_n) // R5
        evalStrobe && posSel == 2'h3 && !wide_sector_bit |=> posLimit == POS_60)
        else $error("pattern 11 not +60");
    // R5 positive eighty
    pos_eighty_a: assert property (@(posedge mclk) disable iff (!arst_n) // R5
        evalStrobe && posSel == 2'h0 && !wide_sector_bit |=> posLimit == POS_80)
        else $error("pattern 00 not +80");
    // R5 positive seventy
    pos_seventy_a: assert property (@(posedge mclk) disable iff (!arst_n) // R5
        evalStrobe && posSel == 2'h1 && !wide_sector_bit |=> posLimit == POS_70)
        else $error("pattern 10 not +70");
    // R6 wide positive
    pos_wide_a: assert property (@(posedge mclk) disable iff (!arst_n) // R6
        evalStrobe && posSel == 2'h1 && wide_sector_bit |=> posLimit == POS_70 + WIDE_SHIFT)
        else $error("wide +70 not +78");
    // R6 wide eighty
    pos_eighty_wide_a: assert property (@(posedge mclk) disable iff (!arst_n) // R6
        evalStrobe && posSel == 2'h0 && wide_sector_bit |=> posLimit == POS_80 + WIDE_SHIFT)
        else $error("wide +80 not +88");
    // R6 wide sixty
    pos_sixty_wide_a: assert property (@(posedge mclk) disable iff (!arst_n) // R6
        evalStrobe && posSel == 2'h2 && wide_sector_bit |=> posLimit == POS_60 + WIDE_SHIFT)
        else $error("wide pattern 01 not +68");
    // R6 wide both positive
    pos_both_wide_a: assert property (@(posedge mclk) disable iff (!arst_n) // R6
        evalStrobe && posSel == 2'h3 && wide_sector_bit |=> posLimit == POS_60 + WIDE_SHIFT)
        else $error("wide pattern 11 not +68");

    // R3 storage retention
    keep_storage_a: assert property (@(posedge mclk) disable iff (!arst_n) // R3
        keepOnSupplyLoss |-> $past(record_storage_select) && $past(recordHasTrip))
        else $error("retention without non-volatile trip record");
    // R3 volatile never kept
    keep_volatile_a: assert property (@(posedge mclk) disable iff (!arst_n) // R3
        !record_storage_select |=> !keepOnSupplyLoss)
        else $error("volatile records marked for retention");
    // R8 trip record kept
    keep_trip_a: assert property (@(posedge mclk) disable iff (!arst_n) // R8
        record_storage_select && recordHasTrip |=> keepOnSupplyLoss)
        else $error("non-volatile trip record not retained");

    // Covers mark the scenarios the bench is meant to reach
    wide_cover: cover property (@(posedge mclk) evalStrobe && wide_sector_bit);
    mixed_cover: cover property (@(posedge mclk) evalStrobe && negSel == 2'h2);
    remote_cover: cover property (@(posedge mclk) remoteWrite ##[1:4] evalStrobe);
    clash_cover: cover property (@(posedge mclk) remoteWrite && panelWrite);
    keep_cover: cover property (@(posedge mclk) keepOnSupplyLoss);
endmodule : earth_fault_sector_config

// ==== test/sw_host.sv ====
// Behavioural front panel and serial host that write the option switchgroup.
// Assumes the decoder samples its write strobes on the rising mclk edge.
`timescale 1ns/1ps
module sw_host (
    input wire logic mclk,
    output logic panelWrite,
    output logic [7:0] panelData,
    output logic remoteWrite,
    output logic [7:0] remoteData
);
    initial {panelWrite, remoteWrite, panelData, remoteData} = 18'h00000;
    task put(input logic p, r, input logic [7:0] pv, rv);
        @(negedge mclk);
        {panelWrite, remoteWrite, panelData, remoteData} = {p, r, pv, rv};
        @(negedge mclk);
        // Released data inverted so a stale value cannot pass as held
        {panelWrite, remoteWrite, panelData, remoteData} = {2'h0, ~pv, ~rv};
    endtask : put
endmodule : sw_host

// ==== test/tb.sv ====
// Self-checking bench for the earth-fault sector configuration decoder.
// Assumes sw_host makes the writes; the bench drives strobes at the falling edge.
`timescale 1ns/1ps
module tb;
    import ef_sector_pkg::*;
    typedef struct {logic [7:0] sw; logic w; logic [7:0] ng, ps; logic [1:0] np, pp;} row_t;
    logic mclk = 1'b0, arst_n = 1'b0, wide_sector_bit = 1'b0, evalStrobe = 1'b0;
    logic recordHasTrip = 1'b0, panelWrite, remoteWrite, keep;
    logic [7:0] panelData, remoteData, switches, negLimit, posLimit;
    principle_t negPrinciple, posPrinciple;
    int errors = 0, checked = 0;
    row_t rows [7] = '{'{8'h00, 1'b0, 8'h50, 8'h50, 2'h1, 2'h1},
        '{8'h01, 1'b1, 8'h58, 8'h58, 2'h2, 2'h2}, '{8'h14, 1'b0, 8'h78, 8'h46, 2'h1, 2'h2},
        '{8'h29, 1'b1, 8'hAA, 8'h44, 2'h1, 2'h2}, '{8'h3D, 1'b0, 8'h78, 8'h3C, 2'h1, 2'h2},
        '{8'h34, 1'b1, 8'h78, 8'h44, 2'h1, 2'h2}, '{8'h10, 1'b1, 8'h58, 8'h4E, 2'h1, 2'h1}};
    always #25 mclk = ~mclk;
    sw_host host (.mclk(mclk), .panelWrite(panelWrite), .panelData(panelData),
        .remoteWrite(remoteWrite), .remoteData(remoteData));
    earth_fault_sector_config uut (.mclk(mclk), .arst_n(arst_n), .panelWrite(panelWrite),
        .panelData(panelData), .remoteWrite(remoteWrite), .remoteData(remoteData),
        .wide_sector_bit(wide_sector_bit), .evalStrobe(evalStrobe),
        .recordHasTrip(recordHasTrip), .earth_fault_option_switches(switches),
        .negPrinciple(negPrinciple), .posPrinciple(posPrinciple), .negLimit(negLimit),
        .posLimit(posLimit), .keepOnSupplyLoss(keep));
    task chk(input logic [7:0] g, e);
        checked++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %0t got %h expected %h", $time, g, e);
        end
    endtask : chk
    task evalNow();
        @(negedge mclk) evalStrobe = 1'b1;
        @(negedge mclk) evalStrobe = 1'b0;
    endtask : evalNow
    task wrap_up();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : wrap_up
    initial begin
        #20000;
        errors++;
        wrap_up();
    end
    initial begin
        repeat (16) @(negedge mclk);
        chk(switches, 8'h00);
        chk(negLimit, 8'h50);
        chk({6'h00, posPrinciple}, 8'h01);
        arst_n = 1'b1;
        // Ordinary decodes, alternating write paths
        for (int i = 0; i < 7; i++) begin
            host.put(i[0], !i[0], rows[i].sw, rows[i].sw);
            wide_sector_bit = rows[i].w;
            chk(switches, rows[i].sw);
            evalNow();
            chk(negLimit, rows[i].ng);
            chk(posLimit, rows[i].ps);
            chk({6'h00, negPrinciple}, {6'h00, rows[i].np});
            chk({6'h00, posPrinciple}, {6'h00, rows[i].pp});
        end
        host.put(1'b1, 1'b0, 8'h08, 8'h00);
        wide_sector_bit = 1'b0;
        @(negedge mclk);
        chk(negLimit, 8'h58);
        evalNow();
        chk(negLimit, 8'hAA);
        host.put(1'b1, 1'b1, 8'h02, 8'h04);
        chk(switches, 8'h04);
        recordHasTrip = 1'b1;
        @(negedge mclk);
        chk({7'h00, keep}, 8'h00);
        host.put(1'b0, 1'b1, 8'h00, 8'h02);
        @(negedge mclk);
        chk({7'h00, keep}, 8'h01);
        recordHasTrip = 1'b0;
        @(negedge mclk);
        chk({7'h00, keep}, 8'h00);
        arst_n = 1'b0;
        @(negedge mclk);
        chk(switches, 8'h00);
        chk(negLimit, 8'h50);
        wrap_up();
    end
endmodule : tb
